// ==== design/ars_register_set.sv ====
// architectural register set: integer, float, flags, link, count, exception
// assumes core units drive every input on mclk; reads return next cycle
`timescale 1ns/10ps
module ars_register_set (
  // clock and reset
  input  wire logic                   mclk,
  input  wire logic                   rst_n,
  // integer register ports
  input  wire logic [4:0]             intRdAddrA,
  input  wire logic [4:0]             intRdAddrB,
  input  wire ars_pkg::ars_iwr_type   intWr,
  output logic [31:0]                 intRdDataA,
  output logic [31:0]                 intRdDataB,
  // float register ports
  input  wire logic [4:0]             fltRdAddrA,
  input  wire logic [4:0]             fltRdAddrB,
  input  wire logic [4:0]             fltStAddr,
  input  wire ars_pkg::ars_fwr_type   fltWr,
  input  wire logic [31:0]            fltStatus,
  output logic [63:0]                 fltRdDataA,
  output logic [63:0]                 fltRdDataB,
  output logic [31:0]                 fltStSingle,
  // flags
  input  wire ars_pkg::ars_flagop_type flagOp,
  output logic [31:0]                 flagsOut,
  // special register moves
  input  wire logic                   sprWrEn,
  input  wire logic [9:0]             sprWrNum,
  input  wire logic [31:0]            sprWrData,
  input  wire logic [9:0]             sprRdNum,
  output logic [31:0]                 sprRdData,
  // branch unit
  input  wire logic                   countDec,
  input  wire logic                   linkWrEn,
  input  wire logic [31:0]            linkWrData,
  output logic [31:0]                 linkOut,
  output logic [31:0]                 countOut,
  output logic [31:0]                 excOut
);

  // =========================================================
  // field helpers; field 0 is the most significant nibble
  function automatic logic [31:0] fieldMask(input logic [2:0] f);
    return 32'hF0000000 >> {f, 2'b00};
  endfunction

  function automatic logic [3:0] getField(input logic [31:0] w, input logic [2:0] f);
    logic [31:0] t;
    t = w << {f, 2'b00};
    return t[31:28];
  endfunction

  function automatic logic [31:0] setField(input logic [31:0] w, input logic [2:0] f,
                                           input logic [3:0] n);
    return (w & ~fieldMask(f)) | ({n, 28'h0000000} >> {f, 2'b00});
  endfunction

  // =========================================================
  // format conversion
  function automatic logic [63:0] sglToDbl(input logic [31:0] s);
    logic [10:0] de;
    logic [51:0] df;
    df = {s[22:0], 29'h00000000};
    de = 11'h000;
    if (s[30:23] == ars_pkg::SEXP_ALL1) begin
      de = ars_pkg::DEXP_ALL1;
    end else if (s[30:23] != 8'h00) begin
      de = {3'h0, s[30:23]} + ars_pkg::DEXP_BIAS_D;
    end else if (s[22:0] != 23'h000000) begin
      // denormal single becomes a normal double: slide the leading one out
      de = ars_pkg::DEXP_MIN_S;
      for (int i = 0; i < 23; i++) begin
        if (!df[51]) begin
          df = {df[50:0], 1'b0};
          de = de - 11'h001;
        end
      end
      df = {df[50:0], 1'b0};
      de = de - 11'h001;
    end
    return {s[31], de, df};
  endfunction

  // input must be single-representable; extra fraction bits are dropped
  function automatic logic [31:0] dblToSgl(input logic [63:0] d);
    logic [10:0] de;
    logic [10:0] sh;
    logic [23:0] m;
    logic [7:0]  se;
    logic [22:0] sf;
    de = d[62:52];
    sh = ars_pkg::DEXP_MIN_S - de;
    m  = {1'b1, d[51:29]};
    se = 8'h00;
    sf = d[51:29];
    if (de == ars_pkg::DEXP_ALL1) begin
      se = ars_pkg::SEXP_ALL1;
    end else if (de >= ars_pkg::DEXP_MIN_S) begin
      se = 8'(de - ars_pkg::DEXP_BIAS_D);
    end else if (de == 11'h000 || sh > 11'h018) begin
      sf = 23'h000000;
    end else begin
      m  = m >> sh;
      sf = m[22:0];
    end
    return {d[63], se, sf};
  endfunction

  // =========================================================
  // storage
  logic [31:0] intMem [ars_pkg::NREG];
  logic [63:0] fltMem [ars_pkg::NREG];
  logic [31:0] flagsReg;
  logic [31:0] flagsNext;
  logic [31:0] excReg;
  logic [31:0] excNext;
  logic [31:0] linkReg;
  logic [31:0] linkNext;
  logic [31:0] countReg;
  logic [31:0] countNext;
  logic [31:0] sprRd_reg;

  // =========================================================
  // decoding
  wire         sprExcHit   = sprWrEn && sprWrNum == ars_pkg::SPR_EXC;
  wire         sprLinkHit  = sprWrEn && sprWrNum == ars_pkg::SPR_LINK;
  wire         sprCountHit = sprWrEn && sprWrNum == ars_pkg::SPR_COUNT;
  wire [63:0]  fltWrValue  = fltWr.single ? sglToDbl(fltWr.data[31:0])
                                          : fltWr.data;
  wire         intNeg      = intWr.data[31];
  wire         intZero     = intWr.data == ars_pkg::RST_WORD;
  wire [3:0]   intRecNib   = {intNeg, !intNeg && !intZero, intZero,
                              excReg[ars_pkg::SO_BIT]};
  wire [3:0]   cmpNib      = flagOp.cmpInt ? {flagOp.cmpOut[3:1], excReg[ars_pkg::SO_BIT]}
                                           : flagOp.cmpOut;
  wire [31:0]  maskSrc     = intMem[flagOp.bitA];
  wire         logicBitA   = flagsReg[5'd31 - flagOp.bitA];
  wire         logicBitB   = flagsReg[5'd31 - flagOp.bitB];
  wire [31:0]  sprRdValue  = sprRdNum == ars_pkg::SPR_EXC   ? excReg :
                             sprRdNum == ars_pkg::SPR_LINK  ? linkReg :
                             sprRdNum == ars_pkg::SPR_COUNT ? countReg :
                             ars_pkg::RST_WORD;

  logic [31:0] fieldWide;
  for (genvar k = 0; k < 8; k++) begin : g_field_wide
    assign fieldWide[k*4 +: 4] = {4{flagOp.mask[k]}};
  end

  // =========================================================
  // flags next value: explicit op first, then implicit records
  always_comb begin
    flagsNext = flagsReg;
    unique case (flagOp.op)
      ars_pkg::FOP_NONE: begin
      end
      ars_pkg::FOP_MASK: begin
        flagsNext = (flagsReg & ~fieldWide) | (maskSrc & fieldWide);
      end
      ars_pkg::FOP_COPY: begin
        flagsNext = setField(flagsReg, flagOp.dstField,
                             getField(flagsReg, flagOp.srcField));
      end
      ars_pkg::FOP_EXC: begin
        flagsNext = setField(flagsReg, flagOp.dstField,
                             getField(excReg, flagOp.srcField));
      end
      ars_pkg::FOP_FST: begin
        flagsNext = setField(flagsReg, flagOp.dstField,
                             getField(fltStatus, flagOp.srcField));
      end
      ars_pkg::FOP_LOGIC: begin
        flagsNext[5'd31 - flagOp.bitD] = flagOp.truth[{logicBitA, logicBitB}];
      end
      ars_pkg::FOP_CMP: begin
        flagsNext = setField(flagsReg, flagOp.dstField, cmpNib);
      end
      default: begin
      end
    endcase
    if (intWr.en && intWr.record) begin
      flagsNext = setField(flagsNext, 3'h0, intRecNib);
    end
    if (fltWr.en && fltWr.record) begin
      flagsNext = setField(flagsNext, 3'h1, fltStatus[31:28]);
    end
  end

  // =========================================================
  // special registers; a branch update wins over a move in the same cycle
  always_comb begin
    excNext   = sprExcHit ? (sprWrData & ars_pkg::EXC_IMPL) : excReg;
    linkNext  = linkWrEn ? linkWrData : (sprLinkHit ? sprWrData : linkReg);
    countNext = countDec ? countReg - 32'h00000001
                         : (sprCountHit ? sprWrData : countReg);
  end

  // =========================================================
  // register files; reads sample before the same-cycle write lands
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < ars_pkg::NREG; i++) begin
        intMem[i] <= ars_pkg::RST_WORD;
        fltMem[i] <= ars_pkg::RST_DWORD;
      end
    end else begin
      if (intWr.en) begin
        intMem[intWr.addr] <= intWr.data;
      end
      if (fltWr.en) begin
        fltMem[fltWr.addr] <= fltWrValue;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      intRdDataA  <= ars_pkg::RST_WORD;
      intRdDataB  <= ars_pkg::RST_WORD;
      fltRdDataA  <= ars_pkg::RST_DWORD;
      fltRdDataB  <= ars_pkg::RST_DWORD;
      fltStSingle <= ars_pkg::RST_WORD;
    end else begin
      intRdDataA  <= intMem[intRdAddrA];
      intRdDataB  <= intMem[intRdAddrB];
      fltRdDataA  <= fltMem[fltRdAddrA];
      fltRdDataB  <= fltMem[fltRdAddrB];
      fltStSingle <= dblToSgl(fltMem[fltStAddr]);
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      flagsReg  <= ars_pkg::RST_WORD;
      excReg    <= ars_pkg::RST_WORD;
      linkReg   <= ars_pkg::RST_WORD;
      countReg  <= ars_pkg::RST_WORD;
      sprRd_reg <= ars_pkg::RST_WORD;
    end else begin
      flagsReg  <= flagsNext;
      excReg    <= excNext;
      linkReg   <= linkNext;
      countReg  <= countNext;
      sprRd_reg <= sprRdValue;
    end
  end

  assign flagsOut  = flagsReg;
  assign excOut    = excReg;
  assign linkOut   = linkReg;
  assign countOut  = countReg;
  assign sprRdData = sprRd_reg;

  // =========================================================
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_reserved_zero: assert property (
    (excOut & ~ars_pkg::EXC_IMPL) == ars_pkg::RST_WORD)
    else $error("reserved exception bits read nonzero");

  a_int_write: assert property (
    intWr.en |=> intMem[$past(intWr.addr)] == $past(intWr.data))
    else $error("integer write not stored");

  a_int_source_kept: assert property (
    intWr.en && intRdAddrA != intWr.addr
    |=> intMem[$past(intRdAddrA)] == intRdDataA)
    else $error("source register disturbed by write");

  a_float_double: assert property (
    fltWr.en && !fltWr.single |=> fltMem[$past(fltWr.addr)] == $past(fltWr.data))
    else $error("double load altered data");

  a_count_dec: assert property (
    countDec |=> countOut == $past(countOut) - 32'h00000001)
    else $error("count did not decrement");

  a_rec_int: assert property (
    intWr.en && intWr.record && !(fltWr.en && fltWr.record)
    |=> flagsOut[28] == $past(excOut[ars_pkg::SO_BIT])
        && flagsOut[29] == ($past(intWr.data) == ars_pkg::RST_WORD)
        && flagsOut[31] == $past(intWr.data[31]))
    else $error("field 0 record wrong");

  a_rec_flt: assert property (
    fltWr.en && fltWr.record |=> flagsOut[27:24] == $past(fltStatus[31:28]))
    else $error("field 1 record wrong");

  a_copy_others: assert property (
    flagOp.op == ars_pkg::FOP_COPY && !intWr.record && !fltWr.record
    |=> (flagsOut & ~fieldMask($past(flagOp.dstField)))
        == ($past(flagsOut) & ~fieldMask($past(flagOp.dstField))))
    else $error("field copy touched other fields");

  a_spr_exc: assert property (
    sprWrEn && sprWrNum == ars_pkg::SPR_EXC
    |=> excOut == ($past(sprWrData) & ars_pkg::EXC_IMPL))
    else $error("move to exception register failed");

  a_flags_hold: assert property (
    flagOp.op == ars_pkg::FOP_NONE && !(intWr.en && intWr.record)
    && !(fltWr.en && fltWr.record) |=> $stable(flagsOut))
    else $error("flags changed with no operation");

endmodule

// ==== include/ars_pkg.sv ====
// constants, types and carriers for the architectural register set
// assumes a single core clock; all ports are driven by same-clock core logic
//
// Summary of operation
// - reserved register bits always read as zero, whatever was written.
// - destination may differ from both sources; sources remain intact after write.
// - integer register file holds 32 entries for operands and addresses.
// - integer, link and count registers are 32 bits in this build.
// - float register file holds 32 entries of 64 bits, double format.
// - double-word float loads and stores move 64 bits unchanged.
// - single float load converts to double before writing the register.
// - single float store converts register double value to single format.
// - float results arrive already rounded from unbounded intermediate precision.
// - float arithmetic except compares writes a float register; status follows.
// - flags register is 32 bits as eight independent 4-bit fields.
// - field-mask write updates only selected fields from an integer register.
// - field copy moves one 4-bit field into another, others unchanged.
// - exception-register field is copied into a selected flags field.
// - float status field is copied into a selected flags field.
// - flag logic combines two addressed bits into one addressed bit.
// - recorded integer operation updates field 0 implicitly.
// - recorded float operation updates field 1 implicitly.
// - compare outcome goes into the field that the operation names.
// - special move reaches the integer exception register as number 1.
// - count register decrements on branch and supplies a branch target.
// - field 0 holds negative, positive, zero, then summary overflow copy.
// - recorded float result loads field 1 from float status bits 0-3.
package ars_pkg;
  // =========================================================
  // sizes
  localparam int XLEN = 32;
  localparam int FLEN = 64;
  localparam int NREG = 32;
  // =========================================================
  // special register numbers and reset values
  localparam logic [9:0]  SPR_EXC     = 10'h001;
  localparam logic [9:0]  SPR_LINK    = 10'h008;
  localparam logic [9:0]  SPR_COUNT   = 10'h009;
  // implemented exception-register bits: summary flags on top, byte count below
  localparam logic [31:0] EXC_IMPL    = 32'hE000007F;
  localparam logic [31:0] RST_WORD    = 32'h00000000;
  localparam logic [63:0] RST_DWORD   = 64'h0000000000000000;
  localparam int          SO_BIT      = 31;
  // =========================================================
  // float format constants
  localparam logic [10:0] DEXP_BIAS_D = 11'h380;
  localparam logic [10:0] DEXP_MIN_S  = 11'h381;
  localparam logic [10:0] DEXP_ALL1   = 11'h7FF;
  localparam logic [7:0]  SEXP_ALL1   = 8'hFF;
  // =========================================================
  // flag operations
  typedef enum logic [2:0] {
    FOP_NONE  = 3'h0,
    FOP_MASK  = 3'h1,
    FOP_EXC   = 3'h2,
    FOP_COPY  = 3'h3,
    FOP_CMP   = 3'h5,
    FOP_FST   = 3'h6,
    FOP_LOGIC = 3'h7
  } ars_fop_type;

  typedef struct packed {
    logic        en;
    logic [4:0]  addr;
    logic        record;
    logic [31:0] data;
  } ars_iwr_type;

  typedef struct packed {
    logic        en;
    logic [4:0]  addr;
    logic        single;
    logic        record;
    logic [63:0] data;
  } ars_fwr_type;

  typedef struct packed {
    ars_fop_type op;
    logic [2:0]  dstField;
    logic [2:0]  srcField;
    logic [7:0]  mask;
    logic [4:0]  bitA;
    logic [4:0]  bitB;
    logic [4:0]  bitD;
    logic [3:0]  truth;
    logic        cmpInt;
    logic [3:0]  cmpOut;
  } ars_flagop_type;
endpackage

// ==== tb/architectural_register_set_bench.sv ====
// self-checking bench for the architectural register set
// assumes inputs change on the falling edge and reads answer one edge later
`timescale 1ns/10ps
module architectural_register_set_bench;
  logic                   mclk, rst_n, loadReq, loadIdx, decReq, countDec;
  logic                   sprWrEn, linkWrEn;
  logic [4:0]             intRdAddrA, intRdAddrB, fltRdAddrA, fltRdAddrB, fltStAddr, loadAddr;
  logic [9:0]             sprWrNum, sprRdNum;
  logic [31:0]            intRdDataA, intRdDataB, fltStatus, fltStSingle, flagsOut;
  logic [31:0]            sprWrData, sprRdData, linkWrData, linkOut, countOut, excOut;
  logic [63:0]            fltRdDataA, fltRdDataB;
  ars_pkg::ars_iwr_type   intWr;
  ars_pkg::ars_fwr_type   benchFltWr, unitFltWr, fltWr;
  ars_pkg::ars_flagop_type flagOp;
  int                     fails, samplesChecked;
  // ==========================================================
  // instances
  assign fltWr = unitFltWr.en ? unitFltWr : benchFltWr;
  ars_register_set u_dut (.mclk(mclk), .rst_n(rst_n), .intRdAddrA(intRdAddrA),
    .intRdAddrB(intRdAddrB), .intWr(intWr), .intRdDataA(intRdDataA), .intRdDataB(intRdDataB),
    .fltRdAddrA(fltRdAddrA), .fltRdAddrB(fltRdAddrB), .fltStAddr(fltStAddr), .fltWr(fltWr),
    .fltStatus(fltStatus), .fltRdDataA(fltRdDataA), .fltRdDataB(fltRdDataB),
    .fltStSingle(fltStSingle), .flagOp(flagOp), .flagsOut(flagsOut), .sprWrEn(sprWrEn),
    .sprWrNum(sprWrNum), .sprWrData(sprWrData), .sprRdNum(sprRdNum), .sprRdData(sprRdData),
    .countDec(countDec), .linkWrEn(linkWrEn), .linkWrData(linkWrData), .linkOut(linkOut),
    .countOut(countOut), .excOut(excOut));
  ars_unit_model u_unit (.mclk(mclk), .loadReq(loadReq), .loadAddr(loadAddr),
    .loadIdx(loadIdx), .decReq(decReq), .fltWrOut(unitFltWr), .countDec(countDec));
  // ==========================================================
  // helpers
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    samplesChecked++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic iwr(input logic [4:0] a, input logic [31:0] d, input logic rec);
    intWr <= '{en: 1'b1, addr: a, record: rec, data: d};
    cyc(1);
    intWr.en <= 1'b0;
    cyc(1);
  endtask
  task automatic sprw(input logic [9:0] n, input logic [31:0] d);
    sprWrEn <= 1'b1;
    sprWrNum <= n;
    sprWrData <= d;
    cyc(1);
    sprWrEn <= 1'b0;
    cyc(1);
  endtask
  function automatic ars_pkg::ars_flagop_type mk(input ars_pkg::ars_fop_type op,
      input int dst, src, input logic [7:0] m, input int a, b, d,
      input logic [3:0] t, input logic ci, input logic [3:0] co);
    return '{op: op, dstField: 3'(dst), srcField: 3'(src), mask: m, bitA: 5'(a),
             bitB: 5'(b), bitD: 5'(d), truth: t, cmpInt: ci, cmpOut: co};
  endfunction
  task automatic endSim();
    $display("checks %0d mismatches %0d", samplesChecked, fails);
    if (fails == 0 && samplesChecked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // ==========================================================
  // scenarios
  task automatic testInt();
    for (int i = 0; i < 32; i++) begin
      iwr(5'(i), 32'hA5000000 | i, 1'b0);
    end
    for (int i = 0; i < 32; i++) begin
      intRdAddrA <= 5'(i);
      cyc(1);
      chk("integer entry", {32'h0, 32'hA5000000 | i}, {32'h0, intRdDataA});
    end
    // write a third entry while both sources are read in the same cycle
    intRdAddrA <= 5'h01;
    intRdAddrB <= 5'h02;
    iwr(5'h03, 32'hFFFFFFFF, 1'b0);
    chk("source a", 64'hA5000001, {32'h0, intRdDataA});
    chk("source b", 64'hA5000002, {32'h0, intRdDataB});
    intRdAddrA <= 5'h03;
    cyc(2);
    chk("destination", 64'hFFFFFFFF, {32'h0, intRdDataA});
    chk("source kept", 64'hA5000002, {32'h0, intRdDataB});
    $display("integer file test done");
  endtask
  task automatic testFloat();
    logic [63:0] dbl[2];
    logic [31:0] sgl[2];
    dbl = '{64'h3FF0000000000000, 64'hC008000000000000};
    sgl = '{32'h3F800000, 32'hC0400000};
    benchFltWr <= '{en: 1'b1, addr: 5'h1F, single: 1'b0, record: 1'b0,
                    data: 64'hC00921FB54442D18};
    cyc(1);
    benchFltWr.en <= 1'b0;
    fltRdAddrA <= 5'h1F;
    cyc(2);
    chk("double entry", 64'hC00921FB54442D18, fltRdDataA);
    for (int i = 0; i < 2; i++) begin
      loadReq <= 1'b1;
      loadIdx <= i[0];
      loadAddr <= 5'(4 + i);
      cyc(1);
      loadReq <= 1'b0;
      fltRdAddrB <= 5'(4 + i);
      fltStAddr <= 5'(4 + i);
      cyc(4);
      chk("single load", dbl[i], fltRdDataB);
      chk("single store", {32'h0, sgl[i]}, {32'h0, fltStSingle});
    end
    chk("double kept", 64'hC00921FB54442D18, fltRdDataA);
    $display("float file test done");
  endtask
  task automatic testSpecial();
    sprw(ars_pkg::SPR_EXC, 32'hFFFFFFFF);
    sprRdNum <= ars_pkg::SPR_EXC;
    cyc(2);
    chk("exception read", {32'h0, ars_pkg::EXC_IMPL}, {32'h0, sprRdData});
    chk("exception out", {32'h0, ars_pkg::EXC_IMPL}, {32'h0, excOut});
    sprw(ars_pkg::SPR_COUNT, 32'h00000003);
    repeat (2) begin
      decReq <= 1'b1;
      cyc(1);
      decReq <= 1'b0;
      cyc(1);
    end
    cyc(2);
    chk("count", 64'h1, {32'h0, countOut});
    linkWrEn <= 1'b1;
    linkWrData <= 32'h00000040;
    cyc(1);
    linkWrEn <= 1'b0;
    sprRdNum <= ars_pkg::SPR_LINK;
    cyc(2);
    chk("link", 64'h40, {32'h0, linkOut});
    chk("link read", 64'h40, {32'h0, sprRdData});
    sprw(ars_pkg::SPR_LINK, 32'h00000080);
    chk("link move", 64'h80, {32'h0, linkOut});
    sprRdNum <= 10'h3FF;
    cyc(2);
    chk("unmapped read", 64'h0, {32'h0, sprRdData});
    $display("special register test done");
  endtask
  task automatic testFlags();
    ars_pkg::ars_flagop_type ops[8];
    logic [31:0] exps[8];
    ops[0] = mk(ars_pkg::FOP_MASK, 0, 0, 8'hA0, 5, 0, 0, 4'h0, 1'b0, 4'h0);
    ops[1] = mk(ars_pkg::FOP_COPY, 7, 0, 8'h00, 0, 0, 0, 4'h0, 1'b0, 4'h0);
    ops[2] = mk(ars_pkg::FOP_EXC, 6, 0, 8'h00, 0, 0, 0, 4'h0, 1'b0, 4'h0);
    ops[3] = mk(ars_pkg::FOP_FST, 5, 1, 8'h00, 0, 0, 0, 4'h0, 1'b0, 4'h0);
    // doc bit 3 is set and doc bit 1 is clear, so only truth entry 2 may land
    ops[4] = mk(ars_pkg::FOP_LOGIC, 0, 0, 8'h00, 3, 1, 16, 4'h4, 1'b0, 4'h0);
    ops[5] = mk(ars_pkg::FOP_CMP, 3, 0, 8'h00, 0, 0, 0, 4'h0, 1'b0, 4'h2);
    ops[6] = mk(ars_pkg::FOP_CMP, 2, 0, 8'h00, 0, 0, 0, 4'h0, 1'b1, 4'h4);
    ops[7] = mk(ars_pkg::ars_fop_type'(3'h4), 1, 0, 8'hFF, 0, 0, 0, 4'hF, 1'b0, 4'hF);
    exps = '{32'h10300000, 32'h10300001, 32'h103000E1, 32'h10300CE1,
             32'h10308CE1, 32'h10328CE1, 32'h10528CE1, 32'h10528CE1};
    iwr(5'h05, 32'h12345678, 1'b0);
    fltStatus <= 32'h0C000000;
    chk("flags idle", 64'h0, {32'h0, flagsOut});
    for (int i = 0; i < 8; i++) begin
      flagOp <= ops[i];
      cyc(1);
      flagOp <= '0;
      cyc(1);
      chk("flags op", {32'h0, exps[i]}, {32'h0, flagsOut});
    end
    iwr(5'h07, 32'h80000000, 1'b1);
    cyc(1);
    chk("integer record", 64'h90528CE1, {32'h0, flagsOut});
    fltStatus <= 32'h50000000;
    benchFltWr <= '{en: 1'b1, addr: 5'h02, single: 1'b0, record: 1'b1, data: 64'h0};
    cyc(1);
    benchFltWr.en <= 1'b0;
    cyc(1);
    chk("float record", 64'h95528CE1, {32'h0, flagsOut});
    $display("flags test done");
  endtask
  task automatic testReset();
    rst_n <= 1'b0;
    cyc(2);
    chk("reset flags", 64'h0, {32'h0, flagsOut});
    chk("reset exception", 64'h0, {32'h0, excOut});
    chk("reset link", 64'h0, {32'h0, linkOut});
    rst_n <= 1'b1;
    intRdAddrA <= 5'h05;
    cyc(2);
    chk("reset entry", 64'h0, {32'h0, intRdDataA});
    $display("reset test done");
  endtask
  // ==========================================================
  // clock, reset, sequence and watchdog
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  initial begin
    {rst_n, loadReq, loadIdx, decReq, sprWrEn, linkWrEn} = '0;
    {intRdAddrA, intRdAddrB, fltRdAddrA, fltRdAddrB, fltStAddr, loadAddr} = '0;
    {sprWrNum, sprRdNum, fltStatus, sprWrData, linkWrData} = '0;
    intWr = '0;
    benchFltWr = '0;
    flagOp = '0;
    fails = 0;
    samplesChecked = 0;
    cyc(16);
    rst_n <= 1'b1;
    cyc(1);
    chk("reset count", 64'h0, {32'h0, countOut});
    testInt();
    testFloat();
    testSpecial();
    testFlags();
    testReset();
    endSim();
  end
  initial begin
    #(50 * 2000);
    fails++;
    endSim();
  end
endmodule

// ==== tb/ars_unit_model.sv ====
// partner model: load and branch units that face the register set
// assumes the bench raises requests just after a falling edge of mclk
`timescale 1ns/10ps
module ars_unit_model (
  // clock
  input  wire logic            mclk,
  // requests from the bench
  input  wire logic            loadReq,
  input  wire logic [4:0]      loadAddr,
  input  wire logic            loadIdx,
  input  wire logic            decReq,
  // towards the register set
  output ars_pkg::ars_fwr_type fltWrOut,
  output logic                 countDec
);
  // ==========================================================
  // drivers
  // only single-representable words are loaded, so the conversion stays defined
  logic [31:0] singleWord;
  assign singleWord = loadIdx ? 32'hC0400000 : 32'h3F800000;
  always @(negedge mclk) begin
    fltWrOut <= '{en: loadReq, addr: loadAddr, single: 1'b1, record: 1'b0,
                  data: {32'h00000000, singleWord}};
    countDec <= decReq;
  end
endmodule
